// File: tcm_pkg.sv
package tcm_pkg;

   // counter and channel geometry
   localparam int CNT_W        = 16;
   localparam int NUM_CH       = 6;
   localparam int CH_IDX_W     = 3;

   // register byte offsets
   localparam logic [7:0] OFS_CTRL   = 8'h00;
   localparam logic [7:0] OFS_MOD    = 8'h04;
   localparam logic [7:0] OFS_INIT   = 8'h08;
   localparam logic [7:0] OFS_CNT    = 8'h0C;
   localparam logic [7:0] OFS_STAT   = 8'h10;
   localparam logic [7:0] OFS_CH0SC  = 8'h20;
   localparam logic [7:0] OFS_CH0V   = 8'h40;
   localparam logic [7:0] OFS_CH_LIM = 8'h60;
   localparam int         CH_IDX_LSB = 2;

   // control register fields
   localparam int CTRL_CLKSEL    = 0;
   localparam int CTRL_CENTRE    = 1;
   localparam int CTRL_QUAD      = 2;
   localparam int CTRL_SIGNED    = 3;
   localparam int CTRL_OE_LSB    = 8;
   localparam int CTRL_JOIN_LSB  = 16;
   localparam int CTRL_DCAP_LSB  = 20;
   localparam int PAIRS          = 3;

   // channel status/control fields
   localparam int SC_ELS_LSB  = 0;
   localparam int SC_MS_LSB   = 2;
   localparam int SC_FLAG     = 4;

   localparam logic [1:0] ELS_RISE   = 2'h1;
   localparam logic [1:0] ELS_FALL   = 2'h2;
   localparam logic [1:0] ELS_BOTH   = 2'h3;
   localparam logic [1:0] MS_CAPTURE = 2'h0;
   localparam logic [1:0] MS_COMPARE = 2'h1;

   localparam logic [CNT_W-1:0] MOD_RST = 16'hFFFF;
   localparam logic [CNT_W-1:0] CNT_ONE = 16'h0001;
   localparam logic [31:0]      ZERO32  = 32'h0000_0000;
   localparam logic [1:0]       RESP_OK = 2'h0;
   localparam logic [1:0]       RESP_SLVERR = 2'h2;

   // clocking limits
   localparam int TCLK_MAX_MHZ = 60;
   localparam int ACLK_MHZ     = 20;

   typedef enum logic [2:0] {
      TCM_MODE_CAPTURE  = 3'b000,
      TCM_MODE_COMPARE  = 3'b001,
      TCM_MODE_EDGE_PWM = 3'b010,
      TCM_MODE_CTR_PWM  = 3'b011,
      TCM_MODE_JOIN_PWM = 3'b100,
      TCM_MODE_DCAP     = 3'b101,
      TCM_MODE_IDLE     = 3'b110
   } tcm_mode_t;

   typedef struct packed {
      logic [1:0] mode_bits;
      logic [1:0] edge_sel;
   } tcm_chcfg_t;

   typedef struct packed {
      logic        valid;
      logic [31:0] data;
   } tcm_word_t;

endpackage : tcm_pkg

// File: tcm_chan.sv
`timescale 1ns/1ps
// one channel: mode decode, compare/capture and pin output
module tcm_chan
   import tcm_pkg::*;
#(
   parameter int W = CNT_W
)
(
   // clock and reset
   input  wire logic            aclk,
   input  wire logic            aresetn,
   // configuration
   input  wire tcm_pkg::tcm_chcfg_t cfg,
   input  wire logic            centre,
   input  wire logic            quad,
   input  wire logic            join_en,
   input  wire logic            dcap_en,
   input  wire logic            odd,
   input  wire logic            pwm_oe,
   input  wire logic [W-1:0]    cval,
   // time base
   input  wire logic [W-1:0]    cnt,
   input  wire logic            counting,
   input  wire logic            reload,
   input  wire logic            dir_up,
   // pair partner match, and own match to partner
   input  wire logic            mate_match,
   output logic                 own_match,
   // synchronised pin input
   input  wire logic            pin_in,
   // results
   output logic                 pin_out,
   output logic                 pin_oe,
   output logic                 event_q,
   output logic [W-1:0]         capt_q,
   output tcm_pkg::tcm_mode_t   mode
);

   logic         out_q,  out_d;
   logic         oe_q,   oe_d;
   logic         prev_q, prev_d;
   logic         rl_q,   rl_d;
   logic         ev_d;
   logic [W-1:0] capt_d;
   logic         armed_q, armed_d;
   logic         rise, fall, hit;

   // mode decode, priority centre > join > dual-capture > mode bits
   always_comb
   begin
      mode = TCM_MODE_IDLE;
      if (dcap_en && !join_en && !centre)
         mode = TCM_MODE_DCAP;
      else if (join_en && !centre)
         mode = TCM_MODE_JOIN_PWM;
      else if (centre)
         mode = TCM_MODE_CTR_PWM;
      else if (cfg.mode_bits[1] && !quad)
         mode = TCM_MODE_EDGE_PWM;
      else if (cfg.mode_bits == MS_COMPARE)
         mode = TCM_MODE_COMPARE;
      else if (cfg.mode_bits == MS_CAPTURE)
         mode = TCM_MODE_CAPTURE;
   end

   assign own_match = counting && (cnt == cval);
   assign rise      = pin_in && !prev_q;
   assign fall      = !pin_in && prev_q;

   always_comb
   begin
      hit = 1'b0;
      unique case (cfg.edge_sel)
         ELS_RISE: hit = rise;
         ELS_FALL: hit = fall;
         ELS_BOTH: hit = rise || fall;
         default:  hit = 1'b0;
      endcase
   end

   always_comb
   begin
      out_d   = out_q;
      ev_d    = 1'b0;
      capt_d  = capt_q;
      armed_d = armed_q;
      prev_d  = pin_in;
      rl_d    = reload;
      oe_d    = 1'b0;
      unique case (mode)
         TCM_MODE_CAPTURE:
            if (hit)
            begin
               capt_d = cnt;
               ev_d   = 1'b1;
            end
         TCM_MODE_COMPARE:
         begin
            oe_d = pwm_oe;
            if (own_match)
               unique case (cfg.edge_sel)
                  ELS_RISE: out_d = !out_q;
                  ELS_FALL: out_d = 1'b0;
                  ELS_BOTH: out_d = 1'b1;
                  default:  out_d = out_q;
               endcase
            ev_d = own_match;
         end
         TCM_MODE_EDGE_PWM:
         begin
            oe_d = pwm_oe;
            // period edge lands the cycle after reload, while the count
            // shows the initial value; a match there still wins (0 width)
            if (own_match)
               out_d = cfg.edge_sel[0];
            else if (rl_q)
               out_d = !cfg.edge_sel[0];
            ev_d = own_match;
         end
         TCM_MODE_CTR_PWM:
         begin
            oe_d = pwm_oe;
            // up-count match drives edge_sel[0], down-count match its inverse
            if (own_match && dir_up)
               out_d = cfg.edge_sel[0];
            else if (own_match)
               out_d = !cfg.edge_sel[0];
            ev_d = own_match;
         end
         TCM_MODE_JOIN_PWM:
         begin
            oe_d = pwm_oe && !odd;
            if (!odd && own_match)
               out_d = !cfg.edge_sel[0];
            else if (!odd && mate_match)
               out_d = cfg.edge_sel[0];
            ev_d = own_match;
         end
         TCM_MODE_DCAP:
         begin
            // one-shot disarms after a capture; continuous stays armed
            if (!armed_q && cfg.mode_bits[0])
               armed_d = 1'b1;
            if (armed_q && hit)
            begin
               capt_d  = cnt;
               ev_d    = 1'b1;
               armed_d = cfg.mode_bits[0];
            end
         end
         TCM_MODE_IDLE:
            out_d = out_q;
         default:
            out_d = out_q;
      endcase
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         out_q   <= 1'b0;
         oe_q    <= 1'b0;
         prev_q  <= 1'b0;
         event_q <= 1'b0;
         capt_q  <= '0;
         armed_q <= 1'b1;
         rl_q    <= 1'b0;
      end
      else
      begin
         out_q   <= out_d;
         oe_q    <= oe_d;
         prev_q  <= prev_d;
         event_q <= ev_d;
         capt_q  <= capt_d;
         armed_q <= armed_d;
         rl_q    <= rl_d;
      end
   end

   assign pin_out = out_q;
   assign pin_oe  = oe_q;

   property p_oe_gated;
      @(posedge aclk) disable iff (!aresetn)
      !pwm_oe |=> !oe_q;
   endproperty
   a_oe_gated: assert property (p_oe_gated)
      else $error("pin driven without output enable");

   property p_cmp_set;
      @(posedge aclk) disable iff (!aresetn)
      (mode == TCM_MODE_COMPARE && cfg.edge_sel == ELS_BOTH && own_match)
      |=> out_q;
   endproperty
   a_cmp_set: assert property (p_cmp_set)
      else $error("compare set on match failed");

   property p_cmp_clr;
      @(posedge aclk) disable iff (!aresetn)
      (mode == TCM_MODE_COMPARE && cfg.edge_sel == ELS_FALL && own_match)
      |=> !out_q;
   endproperty
   a_cmp_clr: assert property (p_cmp_clr)
      else $error("compare clear on match failed");

   property p_epwm_reload;
      @(posedge aclk) disable iff (!aresetn)
      (mode == TCM_MODE_EDGE_PWM && rl_q && !own_match)
      |=> out_q == !$past(cfg.edge_sel[0]);
   endproperty
   a_epwm_reload: assert property (p_epwm_reload)
      else $error("edge pwm period edge missing at reload");

   property p_capt_rise;
      @(posedge aclk) disable iff (!aresetn)
      (mode == TCM_MODE_CAPTURE && cfg.edge_sel == ELS_RISE && rise)
      |=> event_q && capt_q == $past(cnt);
   endproperty
   a_capt_rise: assert property (p_capt_rise)
      else $error("rising capture missed");
endmodule : tcm_chan

// File: tcm_timer.sv
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module tcm_timer
   import tcm_pkg::*;
#(
   parameter int N_CH = NUM_CH
)
(
   // clock and reset
   input  wire logic                aclk,
   input  wire logic                aresetn,
   // axi4-lite write address
   input  wire logic [7:0]          s_awaddr,
   input  wire logic                s_awvalid,
   output logic                     s_awready,
   // axi4-lite write data
   input  wire logic [31:0]         s_wdata,
   input  wire logic [3:0]          s_wstrb,
   input  wire logic                s_wvalid,
   output logic                     s_wready,
   // axi4-lite write response
   output logic [1:0]               s_bresp,
   output logic                     s_bvalid,
   input  wire logic                s_bready,
   // axi4-lite read address
   input  wire logic [7:0]          s_araddr,
   input  wire logic                s_arvalid,
   output logic                     s_arready,
   // axi4-lite read data
   output logic [31:0]              s_rdata,
   output logic [1:0]               s_rresp,
   output logic                     s_rvalid,
   input  wire logic                s_rready,
   // channel pins
   input  wire logic [N_CH-1:0]     ch_in,
   output logic [N_CH-1:0]          ch_out,
   output logic [N_CH-1:0]          ch_oe
);
   import tcm_pkg::*;

   logic [31:0]      ctrl_q, ctrl_d;
   logic [CNT_W-1:0] mod_q, mod_d, init_q, init_d, cnt_q, cnt_d;
   logic             up_q, up_d;
   logic [3:0]       sc_q [N_CH];
   logic [3:0]       sc_d [N_CH];
   logic [CNT_W-1:0] cv_q [N_CH];
   logic [CNT_W-1:0] cv_d [N_CH];
   logic [N_CH-1:0]  flag_q, flag_d, evt, match, s1_q, s2_q;
   logic [N_CH-1:0]  p_out, p_oe;
   logic [CNT_W-1:0] capt [N_CH];
   tcm_mode_t        mode [N_CH];
   logic             counting, reload, at_top, at_bot;
   // axi state
   tcm_word_t        aw_q, aw_d, w_q, w_d;
   logic             bv_q, bv_d, rv_q, rv_d;
   logic [31:0]      rd_q, rd_d;
   logic [1:0]       br_q, br_d, rr_q, rr_d;
   logic             do_wr;
   logic [7:0]       wa;
   logic [CH_IDX_W-1:0] wi, ri;
   logic             aw_rdy_q, w_rdy_q, ar_rdy_q;

   // pin inputs pass two flops before any channel logic
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s1_q <= '0;
         s2_q <= '0;
      end
      else
      begin
         s1_q <= ch_in;
         s2_q <= s1_q;
      end
   end

   // time base runs on aclk, so timer and bus clock are equal
   assign counting = ctrl_q[CTRL_CLKSEL];
   always_comb
   begin
      // signed mode compares the bounds with $signed operands
      if (ctrl_q[CTRL_SIGNED])
      begin
         at_top = $signed(cnt_q) >= $signed(mod_q);
         at_bot = $signed(cnt_q) <= $signed(init_q);
      end
      else
      begin
         at_top = cnt_q >= mod_q;
         at_bot = cnt_q <= init_q;
      end
   end
   assign reload = counting && at_top && !ctrl_q[CTRL_CENTRE];

   always_comb
   begin
      cnt_d = cnt_q;
      up_d  = up_q;
      if (counting)
      begin
         if (ctrl_q[CTRL_CENTRE])
         begin
            if (up_q && at_top)
               up_d = 1'b0;
            else if (!up_q && at_bot)
               up_d = 1'b1;
            cnt_d = (up_d) ? cnt_q + CNT_ONE : cnt_q - CNT_ONE;
         end
         else if (reload)
            cnt_d = init_q;
         else
            cnt_d = cnt_q + CNT_ONE;
      end
   end

   // channels; instance count set by N_CH (six by default, from NUM_CH)
   generate
      for (genvar i = 0; i < N_CH; i++)
      begin : g_ch
         localparam int MATE = (i % 2 == 0) ? i + 1 : i - 1;
         localparam int PR   = i / 2;
         tcm_chan #(.W(CNT_W)) u_ch (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .cfg        (tcm_chcfg_t'(sc_q[i])),
            .centre     (ctrl_q[CTRL_CENTRE]),
            .quad       (ctrl_q[CTRL_QUAD]),
            .join_en    (ctrl_q[CTRL_JOIN_LSB+PR]),
            .dcap_en    (ctrl_q[CTRL_DCAP_LSB+PR]),
            .odd        ((i % 2) == 1),
            .pwm_oe     (ctrl_q[CTRL_OE_LSB+i]),
            .cval       (cv_q[i]),
            .cnt        (cnt_q),
            .counting   (counting),
            .reload     (reload),
            .dir_up     (up_q),
            .mate_match (MATE < N_CH ? match[MATE % N_CH] : 1'b0),
            .own_match  (match[i]),
            .pin_in     (s2_q[i]),
            .pin_out    (p_out[i]),
            .pin_oe     (p_oe[i]),
            .event_q    (evt[i]),
            .capt_q     (capt[i]),
            .mode       (mode[i])
         );
      end
   endgenerate

   // axi write path: address and data in either order
   assign wa    = aw_q.data[7:0];
   assign wi    = CH_IDX_W'((wa - OFS_CH0SC) >> CH_IDX_LSB);
   assign do_wr = aw_q.valid && w_q.valid && !bv_q;

   always_comb
   begin
      aw_d   = aw_q;
      w_d    = w_q;
      bv_d   = bv_q && !s_bready;
      br_d   = br_q;
      ctrl_d = ctrl_q;
      mod_d  = mod_q;
      init_d = init_q;
      sc_d   = sc_q;
      cv_d   = cv_q;
      flag_d = flag_q | evt;
      if (s_awvalid && !aw_q.valid)
         aw_d = '{valid: 1'b1, data: {24'h00_0000, s_awaddr}};
      if (s_wvalid && !w_q.valid)
         w_d = '{valid: 1'b1, data: s_wdata};
      if (do_wr)
      begin
         aw_d.valid = 1'b0;
         w_d.valid  = 1'b0;
         bv_d       = 1'b1;
         br_d       = RESP_OK;
         if (wa == OFS_CTRL && s_wstrb != 4'h0)
            ctrl_d = w_q.data;
         else if (wa == OFS_MOD)
            mod_d = w_q.data[CNT_W-1:0];
         else if (wa == OFS_INIT)
            init_d = w_q.data[CNT_W-1:0];
         else if (wa == OFS_STAT)
            flag_d = (flag_q & ~w_q.data[N_CH-1:0]) | evt;  // set wins
         else if (wa >= OFS_CH0SC && wa < OFS_CH0SC + 8'(4*N_CH))
            sc_d[wi] = w_q.data[3:0];
         else if (wa >= OFS_CH0V && wa < OFS_CH0V + 8'(4*N_CH))
            cv_d[CH_IDX_W'((wa - OFS_CH0V) >> CH_IDX_LSB)] =
               w_q.data[CNT_W-1:0];
         else if (wa != OFS_CNT)
            br_d = RESP_SLVERR;
      end
   end

   // axi read path
   assign ri = CH_IDX_W'((s_araddr - OFS_CH0V) >> CH_IDX_LSB);
   always_comb
   begin
      rv_d = rv_q && !s_rready;
      rd_d = rd_q;
      rr_d = rr_q;
      if (s_arvalid && !rv_q)
      begin
         rv_d = 1'b1;
         rr_d = RESP_OK;
         rd_d = ZERO32;
         if (s_araddr == OFS_CTRL)
            rd_d = ctrl_q;
         else if (s_araddr == OFS_MOD)
            rd_d = {16'h0000, mod_q};
         else if (s_araddr == OFS_INIT)
            rd_d = {16'h0000, init_q};
         else if (s_araddr == OFS_CNT)
            rd_d = {16'h0000, cnt_q};
         else if (s_araddr == OFS_STAT)
            rd_d = 32'(flag_q);
         else if (s_araddr >= OFS_CH0V && s_araddr < OFS_CH0V + 8'(4*N_CH))
            // capture modes return the latched count, not the compare value
            rd_d = {16'h0000, (mode[ri] == TCM_MODE_CAPTURE ||
                   mode[ri] == TCM_MODE_DCAP) ? capt[ri] : cv_q[ri]};
         else
            rr_d = RESP_SLVERR;
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_q <= ZERO32;
         mod_q  <= MOD_RST;
         init_q <= '0;
         cnt_q  <= '0;
         up_q   <= 1'b1;
         flag_q <= '0;
         aw_q   <= '0;
         w_q    <= '0;
         bv_q   <= 1'b0;
         br_q   <= RESP_OK;
         rv_q   <= 1'b0;
         rd_q   <= ZERO32;
         rr_q   <= RESP_OK;
         ch_out <= '0;
         ch_oe  <= '0;
         aw_rdy_q <= 1'b0;
         w_rdy_q  <= 1'b0;
         ar_rdy_q <= 1'b0;
         for (int i = 0; i < N_CH; i++)
         begin
            sc_q[i] <= 4'h0;
            cv_q[i] <= '0;
         end
      end
      else
      begin
         ctrl_q <= ctrl_d;
         mod_q  <= mod_d;
         init_q <= init_d;
         cnt_q  <= cnt_d;
         up_q   <= up_d;
         flag_q <= flag_d;
         aw_q   <= aw_d;
         w_q    <= w_d;
         bv_q   <= bv_d;
         br_q   <= br_d;
         rv_q   <= rv_d;
         rd_q   <= rd_d;
         rr_q   <= rr_d;
         ch_out <= p_out;
         aw_rdy_q <= !aw_d.valid;
         w_rdy_q  <= !w_d.valid;
         ar_rdy_q <= !rv_d;
         ch_oe  <= p_oe;
         sc_q   <= sc_d;
         cv_q   <= cv_d;
      end
   end

   assign s_awready = aw_rdy_q;
   assign s_wready  = w_rdy_q;
   assign s_bvalid  = bv_q;
   assign s_bresp   = br_q;
   assign s_arready = ar_rdy_q;
   assign s_rvalid  = rv_q;
   assign s_rdata   = rd_q;
   assign s_rresp   = rr_q;

   property p_halt;
      @(posedge aclk) disable iff (!aresetn)
      !counting |=> cnt_q == $past(cnt_q);
   endproperty
   a_halt: assert property (p_halt)
      else $error("counter moved while halted");

   property p_reload;
      @(posedge aclk) disable iff (!aresetn)
      reload |=> cnt_q == $past(init_q);
   endproperty
   a_reload: assert property (p_reload)
      else $error("counter did not reload initial value");

   property p_step;
      @(posedge aclk) disable iff (!aresetn)
      (counting && !ctrl_q[CTRL_CENTRE] && !reload)
      |=> cnt_q == $past(cnt_q) + CNT_ONE;
   endproperty
   a_step: assert property (p_step)
      else $error("counter failed to step up");
endmodule : tcm_timer

// File: tcm_pin_model.sv
`timescale 1ns/1ps
// outside world at the channel pins: loads and an input source
module tcm_pin_model
   import tcm_pkg::*;
#(
   parameter int N = NUM_CH
)
(
   // pins from the timer
   input  wire logic [N-1:0] ch_out,
   input  wire logic [N-1:0] ch_oe,
   // level applied by the outside source
   input  wire logic [N-1:0] src_lvl,
   // resolved pin level back to the timer
   output logic [N-1:0]      ch_in
);
   // a driven pin shows the timer's level, a released one the source's
   assign ch_in = (ch_oe & ch_out) | (~ch_oe & src_lvl);
endmodule : tcm_pin_model

// File: tcm_tb.sv
`timescale 1ns/1ps
module testbench;
   import tcm_pkg::*;
   logic        aclk, aresetn, s_awvalid, s_wvalid, s_bready;
   logic        s_arvalid, s_rready, s_awready, s_wready, s_bvalid;
   logic        s_arready, s_rvalid;
   logic [7:0]  s_awaddr, s_araddr;
   logic [31:0] s_wdata, s_rdata, d, d0;
   logic [3:0]  s_wstrb;
   logic [1:0]  s_bresp, s_rresp, r;
   logic [5:0]  ch_in, ch_out, ch_oe, src_lvl;
   int          n_fail, compares, m, i, c, hi, per;

   tcm_timer #(.N_CH(6)) DUT (.aclk(aclk), .aresetn(aresetn),
      .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
      .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
      .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
      .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
      .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
      .s_rvalid(s_rvalid), .s_rready(s_rready), .ch_in(ch_in),
      .ch_out(ch_out), .ch_oe(ch_oe));
   tcm_pin_model #(.N(6)) pins (.ch_out(ch_out), .ch_oe(ch_oe),
      .src_lvl(src_lvl), .ch_in(ch_in));

   task wrap_up;
      begin
         $display("compares %0d n_fail %0d", compares, n_fail);
         if (n_fail == 0 && compares > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask : wrap_up

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      begin
         compares++;
         if (seen !== exp)
         begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
         end
      end
   endtask : chk

   task axi_wr(input logic [7:0] a, input logic [31:0] wd);
      int   t;
      logic aw_ok, w_ok;
      begin
         @(posedge aclk);
         s_awaddr <= a;
         s_wdata <= wd;
         s_awvalid <= 1'b1;
         s_wvalid <= 1'b1;
         s_bready <= 1'b1;
         aw_ok = 1'b0;
         w_ok = 1'b0;
         t = 0;
         while (!(aw_ok && w_ok) && t < 100)
         begin
            @(posedge aclk);
            t++;
            if (s_awvalid && s_awready === 1'b1) aw_ok = 1'b1;
            if (aw_ok) s_awvalid <= 1'b0;
            if (s_wvalid && s_wready === 1'b1) w_ok = 1'b1;
            if (w_ok) s_wvalid <= 1'b0;
         end
         while (s_bvalid !== 1'b1 && t < 200)
         begin
            @(posedge aclk);
            t++;
         end
         s_bready <= 1'b0;
         if (t >= 200) n_fail++;
         chk("bresp", s_bresp, RESP_OK);
      end
   endtask : axi_wr

   task axi_rd(input logic [7:0] a, output logic [31:0] rd,
               output logic [1:0] rr);
      int t;
      begin
         @(posedge aclk);
         s_araddr <= a;
         s_arvalid <= 1'b1;
         s_rready <= 1'b1;
         t = 0;
         do
         begin
            @(posedge aclk);
            t++;
            if (s_arready === 1'b1) s_arvalid <= 1'b0;
         end
         while (s_arvalid && s_arready !== 1'b1 && t < 100);
         while (s_rvalid !== 1'b1 && t < 200)
         begin
            @(posedge aclk);
            t++;
         end
         s_rready <= 1'b0;
         if (t >= 200) n_fail++;
         rd = s_rdata;
         rr = s_rresp;
      end
   endtask : axi_rd

   // counts cycles until the pin reaches level v, at the settled edge
   task wait_lvl(input int n, input logic v, output int cnt);
      begin
         cnt = 0;
         while (ch_out[n] !== v && cnt < 5000)
         begin
            @(negedge aclk);
            cnt++;
         end
         if (cnt >= 5000) n_fail++;
      end
   endtask : wait_lvl

   // high time and full period, measured from a rising edge
   task meas(input int n, output int h, output int p);
      begin
         wait_lvl(n, 1'b0, p);
         wait_lvl(n, 1'b1, p);
         wait_lvl(n, 1'b0, h);
         wait_lvl(n, 1'b1, p);
         p += h;
      end
   endtask : meas

   initial
   begin
      aclk = 1'b0;
      forever #25 aclk = ~aclk;
   end

   initial
   begin
      repeat (30000) @(posedge aclk);
      n_fail++;
      wrap_up;
   end

   initial
   begin
      {aresetn, s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} = '0;
      {s_awaddr, s_araddr, s_wdata, src_lvl} = '0;
      s_wstrb = 4'hF;
      n_fail = 0;
      compares = 0;
      void'($urandom(32'h31b9));
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(OFS_MOD, d, r);
      chk("mod_reset", d, {16'h0000, MOD_RST});
      axi_rd(OFS_CNT, d0, r);
      repeat (5) @(posedge aclk);
      axi_rd(OFS_CNT, d, r);
      chk("cnt_halted", d, d0);
      chk("oe_reset", {26'h0, ch_oe}, ZERO32);
      axi_rd(8'h64, d, r);
      chk("unmapped_resp", {30'h0, r}, {30'h0, RESP_SLVERR});
      for (int k = 0; k < 3; k++)
      begin
         // modulo only grows, so a halted count never sits above it
         m = 20 + 40 * k + $urandom % 40;
         i = $urandom % 8;
         c = i + 1 + $urandom % (m - i - 1);
         axi_wr(OFS_MOD, m);
         axi_wr(OFS_INIT, i);
         axi_wr(OFS_CH0SC, 32'h0000_000A);
         axi_wr(OFS_CH0V, c);
         axi_wr(OFS_CH0SC + 8'h04, 32'h0000_0005);
         axi_wr(OFS_CH0V + 8'h04, c);
         axi_wr(OFS_CH0SC + 8'h08, 32'h0000_0001);
         // channel 3 sets on match now and clears on match further down
         axi_wr(OFS_CH0SC + 8'h0C, 32'h0000_0007);
         axi_wr(OFS_CH0V + 8'h0C, c);
         axi_wr(OFS_CTRL, 32'h0000_0B01);
         meas(0, hi, per);
         chk("pwm_period", per, m - i + 1);
         chk("pwm_high", hi, c - i);
         meas(1, hi, per);
         chk("toggle_high", hi, m - i + 1);
         chk("cmp_set", ch_out[3], 1'b1);
         chk("oe_set", {26'h0, ch_oe}, 32'h0000_000B);
         @(posedge aclk);
         src_lvl[2] <= 1'b1;
         repeat (8) @(posedge aclk);
         axi_rd(OFS_STAT, d, r);
         chk("rise_captured", d[2], 1'b1);
         axi_rd(OFS_CH0V + 8'h08, d, r);
         chk("capt_in_range", (d >= i && d <= m), 1'b1);
         axi_wr(OFS_STAT, 32'h0000_0004);
         src_lvl[2] <= 1'b0;
         repeat (8) @(posedge aclk);
         axi_rd(OFS_STAT, d, r);
         chk("fall_ignored", d[2], 1'b0);
         axi_wr(OFS_CH0SC + 8'h0C, 32'h0000_0006);
         repeat (m + 8) @(negedge aclk);
         chk("cmp_clear", ch_out[3], 1'b0);
         axi_wr(OFS_CTRL, ZERO32);
      end
      // a second reset in mid-run must bring the modulo back
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      axi_rd(OFS_MOD, d, r);
      chk("mod_rearm", d, {16'h0000, MOD_RST});
      wrap_up;
   end
endmodule : testbench
